//--- evts_cfg.svh
`ifndef EVTS_CFG_SVH
`define EVTS_CFG_SVH

// =====================================================================
// Register offsets
`define EVTS_ADR_STAMP_LAST 4'h6
`define EVTS_ADR_ADJ        4'h7
`define EVTS_ADR_CTL1       4'hE
`define EVTS_ADR_CTL2       4'hF

// =====================================================================
// Field positions
`define EVTS_CTL1_ENABLE     4
`define EVTS_CTL2_BANK       7
`define EVTS_CTL2_VALID      7
`define EVTS_CTL2_SUPPLY     6
`define EVTS_CTL2_OSC        5
`define EVTS_CTL2_PON        4
`define EVTS_CTL2_EVFLAG     3
`define EVTS_SRC_BIT         7

// =====================================================================
// Reset values
`define EVTS_RST_PON         1'b1
`define EVTS_RST_OSC         1'b1

// =====================================================================
// BCD field masks, seconds through year
`define EVTS_MASK_SEC        8'h7F
`define EVTS_MASK_MIN        8'h7F
`define EVTS_MASK_HOUR       8'h3F
`define EVTS_MASK_WDAY       8'h07
`define EVTS_MASK_MDAY       8'h3F
`define EVTS_MASK_MON        8'h1F
`define EVTS_MASK_YEAR       8'hFF

// =====================================================================
// Timing
`define EVTS_CLK_MHZ         125
`define EVTS_SIMUL_WIN_US    7800
`define EVTS_DEBOUNCE_US     1000
`define EVTS_SIMUL_WIN_CYC   (`EVTS_SIMUL_WIN_US * `EVTS_CLK_MHZ)
`define EVTS_DEBOUNCE_CYC    (`EVTS_DEBOUNCE_US * `EVTS_CLK_MHZ)

`endif

//--- evts_pkg.sv
`default_nettype none
package evts_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_DONE = 3'b100
  } evts_fsm_t;

  typedef struct packed {
    logic        seen_low;
    logic        run;
    logic [19:0] cnt;
    logic        confirm;
  } evts_deb_t;

  typedef struct packed {
    evts_fsm_t       fsm;
    logic [7:0]      ctl1;
    logic [7:0]      adj;
    logic            bank;
    logic            valid;
    logic            supply;
    logic            osc;
    logic            power_on_flag;
    logic            evflag;
    logic [1:0]      src;
    logic [19:0]     win_cnt;
    logic [6:0][7:0] stamps;
    logic [7:0]      rdata;
  } evts_state_t;

endpackage
`default_nettype wire

//--- evts_debounce.sv
`timescale 1ns/100ps
`include "evts_cfg.svh"
`default_nettype none
module evts_debounce #(
  parameter logic [19:0] DEB_CYC = 20'(`EVTS_DEBOUNCE_CYC)
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic arm,
  input  wire logic pin,
  output var  logic confirm
);

  evts_pkg::evts_deb_t s_q;
  evts_pkg::evts_deb_t s_d;

  // =====================================================================
  // Edge qualify and debounce
  always_comb begin
    s_d = s_q;
    s_d.confirm = 1'b0;
    if (!arm) begin
      s_d.seen_low = 1'b0;
      s_d.run = 1'b0;
      s_d.cnt = 20'h00000;
    end else if (!pin) begin
      s_d.seen_low = 1'b1;
      s_d.run = 1'b0;
      s_d.cnt = 20'h00000;
    end else if (s_q.seen_low && !s_q.run) begin
      s_d.run = 1'b1;
      s_d.seen_low = 1'b0;
      s_d.cnt = 20'h00000;
    end else if (s_q.run) begin
      if (s_q.cnt == (DEB_CYC - 20'h00001)) begin
        s_d.confirm = 1'b1;
        s_d.run = 1'b0;
      end else begin
        s_d.cnt = s_q.cnt + 20'h00001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign confirm = s_q.confirm;

endmodule
`default_nettype wire

//--- evts_capture.sv
// Design decision made here: the plain strobed port.
`timescale 1ns/100ps
`include "evts_cfg.svh"
`default_nettype none
module evts_capture #(
  parameter logic [19:0] SIMUL_WIN_CYC = 20'(`EVTS_SIMUL_WIN_CYC),
  parameter logic [19:0] DEBOUNCE_CYC  = 20'(`EVTS_DEBOUNCE_CYC)
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output var  logic [7:0] rdata,
  input  wire logic       event_input_a,
  input  wire logic       event_input_b,
  input  wire logic       osc_stop_event,
  input  wire logic       supply_drop_event,
  input  wire logic [7:0] live_sec,
  input  wire logic [7:0] live_min,
  input  wire logic [7:0] live_hour,
  input  wire logic [7:0] live_wday,
  input  wire logic [7:0] live_mday,
  input  wire logic [7:0] live_mon,
  input  wire logic [7:0] live_year,
  output var  logic [7:0] adj_value,
  output var  logic [7:0] ctl1_value,
  output var  logic       bank_sel,
  output var  logic       int_o,
  output var  logic       int_oe_n
);

  evts_pkg::evts_state_t s_q;
  evts_pkg::evts_state_t s_d;

  logic [1:0] confirm;
  logic [1:0] pins;
  logic       arm;

  // =====================================================================
  // Helpers
  function automatic logic [7:0] ctl2_read(input evts_pkg::evts_state_t s);
    logic [7:0] v;
    v = 8'h00;
    v[`EVTS_CTL2_VALID]  = s.valid;
    v[`EVTS_CTL2_SUPPLY] = s.supply;
    v[`EVTS_CTL2_OSC]    = s.osc;
    v[`EVTS_CTL2_PON]    = s.power_on_flag;
    v[`EVTS_CTL2_EVFLAG] = s.evflag;
    return v;
  endfunction

  function automatic logic [7:0] live_field(input logic [2:0] idx,
                                            input logic [55:0] live);
    logic [7:0] v;
    v = 8'h00;
    unique case (idx)
      3'h0: v = live[7:0];
      3'h1: v = live[15:8];
      3'h2: v = live[23:16];
      3'h3: v = live[31:24];
      3'h4: v = live[39:32];
      3'h5: v = live[47:40];
      3'h6: v = live[55:48];
      3'h7: v = 8'h00;
    endcase
    return v;
  endfunction

  function automatic logic [7:0] field_mask(input logic [2:0] idx);
    logic [7:0] m;
    m = 8'h00;
    unique case (idx)
      3'h0: m = `EVTS_MASK_SEC;
      3'h1: m = `EVTS_MASK_MIN;
      3'h2: m = `EVTS_MASK_HOUR;
      3'h3: m = `EVTS_MASK_WDAY;
      3'h4: m = `EVTS_MASK_MDAY;
      3'h5: m = `EVTS_MASK_MON;
      3'h6: m = `EVTS_MASK_YEAR;
      3'h7: m = 8'h00;
    endcase
    return m;
  endfunction

  // =====================================================================
  // Read decode, unmapped offsets read zero
  function automatic logic [7:0] reg_read(input logic [3:0]            a,
                                          input evts_pkg::evts_state_t s,
                                          input logic [55:0]           lv);
    logic [7:0] v;
    v = 8'h00;
    if (a <= `EVTS_ADR_STAMP_LAST) begin
      if (s.bank) begin
        v = s.stamps[a[2:0]];
      end else begin
        v = live_field(a[2:0], lv);
      end
    end else if (a == `EVTS_ADR_ADJ) begin
      v = s.adj;
    end else if (a == `EVTS_ADR_CTL1) begin
      v = s.ctl1;
    end else if (a == `EVTS_ADR_CTL2) begin
      v = ctl2_read(s);
    end
    return v;
  endfunction

  // =====================================================================
  // Timestamp image of the live calendar
  function automatic logic [6:0][7:0] stamp_load(input logic [55:0] lv,
                                                 input logic [1:0]  src);
    logic [6:0][7:0] t;
    t = '0;
    for (int i = 0; i < 7; i++) begin
      t[i] = live_field(3'(i), lv) & field_mask(3'(i));
    end
    t[0][`EVTS_SRC_BIT] = src[0];
    t[1][`EVTS_SRC_BIT] = src[1];
    return t;
  endfunction

  // =====================================================================
  // Control 2 write, flags clear on zero
  function automatic evts_pkg::evts_state_t ctl2_write(input evts_pkg::evts_state_t s,
                                                       input logic [7:0]            d);
    evts_pkg::evts_state_t r;
    r = s;
    r.bank = d[`EVTS_CTL2_BANK];
    if (!d[`EVTS_CTL2_PON]) begin
      r.power_on_flag = 1'b0;
    end
    if (!d[`EVTS_CTL2_OSC]) begin
      r.osc = 1'b0;
    end
    if (!d[`EVTS_CTL2_SUPPLY]) begin
      r.supply = 1'b0;
    end
    if (!d[`EVTS_CTL2_EVFLAG]) begin
      r.evflag = 1'b0;
    end
    return r;
  endfunction

  // =====================================================================
  // Live calendar, seconds in the low byte
  wire logic [55:0] live;
  assign live[7:0]   = live_sec;
  assign live[15:8]  = live_min;
  assign live[23:16] = live_hour;
  assign live[31:24] = live_wday;
  assign live[39:32] = live_mday;
  assign live[47:40] = live_mon;
  assign live[55:48] = live_year;

  // =====================================================================
  // Input debouncers
  // detection gated by enable
  assign arm  = s_q.ctl1[`EVTS_CTL1_ENABLE] && (s_q.fsm != evts_pkg::ST_DONE) && !s_q.evflag;
  assign pins = {event_input_b, event_input_a};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_deb
      evts_debounce #(
        .DEB_CYC (DEBOUNCE_CYC)
      ) u_deb (
        .clk     (clk),
        .rst_n   (rst_n),
        .arm     (arm),
        .pin     (pins[gi]),
        .confirm (confirm[gi])
      );
    end
  endgenerate

  // =====================================================================
  // Next state
  always_comb begin
    logic en_rise;
    en_rise = 1'b0;
    s_d = s_q;

    // ---------------------------------------------------------------
    // Register read, data in the next cycle
    if (rd) begin
      s_d.rdata = reg_read(addr, s_q, live);
    end

    // ---------------------------------------------------------------
    // Register write
    if (wr) begin
      if (addr == `EVTS_ADR_ADJ) begin
        s_d.adj = wdata;
      end else if (addr == `EVTS_ADR_CTL1) begin
        s_d.ctl1 = wdata;
        en_rise = !s_q.ctl1[`EVTS_CTL1_ENABLE] && wdata[`EVTS_CTL1_ENABLE];
        if (!wdata[`EVTS_CTL1_ENABLE]) begin
          s_d.stamps = '0;
          s_d.src = 2'b00;
          s_d.valid = 1'b0;
          s_d.win_cnt = 20'h00000;
          s_d.fsm = evts_pkg::ST_IDLE;
        end
        if (en_rise) begin
          s_d.fsm = evts_pkg::ST_IDLE;
          s_d.src = 2'b00;
          s_d.win_cnt = 20'h00000;
        end
      end else if (addr == `EVTS_ADR_CTL2) begin
        s_d = ctl2_write(s_d, wdata);
      end
    end

    // ---------------------------------------------------------------
    // Detector flags, set wins over clear
    if (osc_stop_event) begin
      s_d.osc = 1'b1;
    end
    if (supply_drop_event) begin
      s_d.supply = 1'b1;
    end

    // ---------------------------------------------------------------
    // Capture sequencer
    if (s_d.ctl1[`EVTS_CTL1_ENABLE] && !en_rise) begin
      unique case (s_q.fsm)
        evts_pkg::ST_IDLE: begin
          if ((confirm != 2'b00) && !s_q.evflag) begin
            s_d.src = confirm;
            s_d.win_cnt = 20'h00000;
            s_d.fsm = evts_pkg::ST_WAIT;
          end
        end
        evts_pkg::ST_WAIT: begin
          s_d.src = s_q.src | confirm;
          if (s_q.win_cnt == (SIMUL_WIN_CYC - 20'h00001)) begin
            s_d.evflag = 1'b1;
            s_d.fsm = evts_pkg::ST_DONE;
            s_d.stamps = stamp_load(live, s_d.src);
            s_d.valid = !s_d.osc && !s_d.supply;
          end else begin
            s_d.win_cnt = s_q.win_cnt + 20'h00001;
          end
        end
        evts_pkg::ST_DONE: begin
          s_d.fsm = evts_pkg::ST_DONE;
        end
      endcase
    end

    // ---------------------------------------------------------------
    // power-on flag forces zeros
    if (s_d.power_on_flag) begin
      s_d.ctl1 = 8'h00;
      s_d.adj = 8'h00;
      s_d.bank = 1'b0;
      s_d.valid = 1'b0;
      s_d.evflag = 1'b0;
      s_d.stamps = '0;
      s_d.src = 2'b00;
      s_d.win_cnt = 20'h00000;
      s_d.fsm = evts_pkg::ST_IDLE;
    end
  end

  // =====================================================================
  // State register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q.fsm     <= evts_pkg::ST_IDLE;
      s_q.ctl1    <= 8'h00;
      s_q.adj     <= 8'h00;
      s_q.bank    <= 1'b0;
      s_q.valid   <= 1'b0;
      s_q.supply  <= 1'b0;
      s_q.osc     <= `EVTS_RST_OSC;
      s_q.power_on_flag     <= `EVTS_RST_PON;
      s_q.evflag  <= 1'b0;
      s_q.src     <= 2'b00;
      s_q.win_cnt <= 20'h00000;
      s_q.stamps  <= '0;
      s_q.rdata   <= 8'h00;
    end else begin
      s_q <= s_d;
    end
  end

  // =====================================================================
  // Outputs
  assign rdata      = s_q.rdata;
  assign adj_value  = s_q.adj;
  assign ctl1_value = s_q.ctl1;
  assign bank_sel   = s_q.bank;
  assign int_o      = 1'b0;
  assign int_oe_n   = !(s_q.evflag && !s_q.power_on_flag);

endmodule
`default_nettype wire

//--- evts_chk.sv
`timescale 1ns/100ps
`default_nettype none
module evts_chk (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic [7:0] adj_value,
  input wire logic [7:0] ctl1_value,
  input wire logic       bank_sel,
  input wire logic       int_oe_n
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // =====================================================================
  // Register port
  reset_quiet_a: assert property (
    $rose(rst_n) |-> int_oe_n && ctl1_value == 8'h00 && adj_value == 8'h00 && !bank_sel)
    else $error("outputs not quiet after reset");
  unmapped_zero_a: assert property (
    rd && addr inside {[4'h8:4'hD]} |=> rdata == 8'h00) else $error("unmapped read not zero");
  ctl2_low_a: assert property (
    rd && addr == 4'hF |=> rdata[2:0] == 3'h0) else $error("control 2 low bits set");
  ctl1_read_a: assert property (
    rd && addr == 4'hE |=> rdata == $past(ctl1_value)) else $error("control 1 read mismatch");
  adj_read_a: assert property (
    rd && addr == 4'h7 |=> rdata == $past(adj_value)) else $error("adjust read mismatch");
  bank_write_a: assert property (
    wr && addr == 4'hF && ctl1_value[4] |=> bank_sel == $past(wdata[7])) else $error("bank not taken");
  // =====================================================================
  // Interrupt pin
  irq_release_a: assert property (
    wr && addr == 4'hF && !wdata[3] |=> int_oe_n) else $error("interrupt not released");
  irq_hold_a: assert property (
    !int_oe_n && !(wr && addr == 4'hF && !wdata[3]) |=> !int_oe_n) else $error("interrupt dropped");
  irq_cause_a: assert property (
    $rose(int_oe_n) |-> $past(wr && addr == 4'hF && !wdata[3])) else $error("interrupt released alone");
  irq_armed_a: assert property (
    $fell(int_oe_n) |-> ctl1_value[4]) else $error("capture while disarmed");
endmodule
`default_nettype wire

//--- evts_src.sv
`timescale 1ns/100ps
`default_nettype none
module evts_src (
  input  wire logic clk,
  output var  logic event_input_a,
  output var  logic event_input_b
);
  initial begin
    event_input_a = 1'b0;
    event_input_b = 1'b0;
  end
  task automatic set_pins(input logic a, input logic b);
    @(posedge clk);
    event_input_a <= a;
    event_input_b <= b;
  endtask
endmodule
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/100ps
`include "evts_cfg.svh"
`default_nettype none
module tb_top;
  localparam logic [19:0] WIN = 20'h00014;
  localparam logic [19:0] DEB = 20'h0000A;
  localparam int CAP = int'(WIN) + int'(DEB) + 3;
  localparam logic [7:0] MASK [7] = '{`EVTS_MASK_SEC, `EVTS_MASK_MIN, `EVTS_MASK_HOUR,
    `EVTS_MASK_WDAY, `EVTS_MASK_MDAY, `EVTS_MASK_MON, `EVTS_MASK_YEAR};
  logic        clk, rst_n, wr, rd, osc_ev, sup_ev, ev_a, ev_b, int_o, int_oe_n, bank_sel, rd_d;
  logic [3:0]  addr;
  logic [7:0]  wdata, rdata, adj_value, ctl1_value;
  logic [7:0]  live [7];
  logic [7:0]  exp_q [$];
  logic [3:0]  adr_q [$];
  logic [31:0] seed;
  int          num_errors, n_compared, cyc;

  evts_capture #(.SIMUL_WIN_CYC(WIN), .DEBOUNCE_CYC(DEB)) i_evts_capture (.clk(clk), .rst_n(rst_n),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .event_input_a(ev_a),
    .event_input_b(ev_b), .osc_stop_event(osc_ev), .supply_drop_event(sup_ev), .live_sec(live[0]),
    .live_min(live[1]), .live_hour(live[2]), .live_wday(live[3]), .live_mday(live[4]),
    .live_mon(live[5]), .live_year(live[6]), .adj_value(adj_value), .ctl1_value(ctl1_value),
    .bank_sel(bank_sel), .int_o(int_o), .int_oe_n(int_oe_n));
  evts_src i_evts_src (.clk(clk), .event_input_a(ev_a), .event_input_b(ev_b));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s exp %h got %h", what, e, g);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back(e);
    adr_q.push_back(a);
    @(posedge clk);
    rd <= 1'b0;
  endtask
  task automatic new_live();
    @(posedge clk);
    for (int i = 0; i < 7; i++) begin
      seed = lfsr(seed);
      live[i] <= {4'(seed[7:4] % 10), 4'(seed[3:0] % 10)};
    end
    #1;
  endtask
  task automatic stamps(input logic z, input logic sa, input logic sb);
    for (int i = 0; i < 7; i++)
      rreg(4'(i), z ? 8'h00 : (live[i] & MASK[i]) | {(i == 0) ? sa : (i == 1) ? sb : 1'b0, 7'h00});
  endtask
  task automatic wait_int(input int lo, input int hi);
    int n;
    n = 0;
    while (int_oe_n !== 1'b0 && n < 60) begin
      @(posedge clk);
      #1;
      n++;
    end
    n_compared++;
    if (n < lo || n > hi) begin
      num_errors++;
      $display("[ERR] capture delay exp %0d..%0d got %0d", lo, hi, n);
    end
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // =====================================================================
  // Read monitor and timeout
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (rd_d && exp_q.size() > 0)
      chk($sformatf("rdata %h", adr_q.pop_front()), exp_q.pop_front(), rdata);
    rd_d <= rd;
  end
  always @(posedge clk) begin
    if (cyc == 4000) begin
      num_errors++;
      close_out();
    end
  end

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // =====================================================================
  // Main sequence
  initial begin
    seed = 32'h2C52406D;
    {rst_n, wr, rd, osc_ev, sup_ev, rd_d} = 6'h00;
    addr = 4'h0;
    wdata = 8'h00;
    {cyc, num_errors, n_compared} = {32'h0, 32'h0, 32'h0};
    foreach (live[i]) live[i] = 8'h00;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rreg(4'hF, 8'h30);
    rreg(4'hE, 8'h00);
    for (int a = 8; a < 14; a++) rreg(4'(a), 8'h00);
    wreg(4'hE, 8'hFF);
    wreg(4'h7, 8'h7D);
    wreg(4'hF, 8'h78);
    rreg(4'hE, 8'h00);
    rreg(4'h7, 8'h00);
    rreg(4'hF, 8'h30);
    wreg(4'hF, 8'h00);
    rreg(4'hF, 8'h00);
    wreg(4'h7, 8'h42);
    rreg(4'h7, 8'h42);
    new_live();
    rreg(4'h0, live[0]);
    wreg(4'hE, 8'h10);
    rreg(4'hE, 8'h10);
    i_evts_src.set_pins(1'b0, 1'b1);
    wait_int(CAP - 3, CAP + 3);
    chk("int_o", 8'h00, {7'h00, int_o});
    i_evts_src.set_pins(1'b0, 1'b0);
    wreg(4'hF, 8'hF8);
    stamps(1'b0, 1'b0, 1'b1);
    rreg(4'hF, 8'h88);
    wreg(4'h0, 8'h5A);
    i_evts_src.set_pins(1'b1, 1'b0);
    repeat (CAP + 5) @(posedge clk);
    stamps(1'b0, 1'b0, 1'b1);
    i_evts_src.set_pins(1'b0, 1'b0);
    wreg(4'hF, 8'hF0);
    #1;
    chk("int_oe_n", 8'h01, {7'h00, int_oe_n});
    wreg(4'hF, 8'hF8);
    rreg(4'hF, 8'h80);
    i_evts_src.set_pins(1'b1, 1'b0);
    wait_int(60, 60);
    wreg(4'hE, 8'h00);
    stamps(1'b1, 1'b0, 1'b0);
    rreg(4'hF, 8'h00);
    i_evts_src.set_pins(1'b0, 1'b0);
    i_evts_src.set_pins(1'b1, 1'b0);
    wait_int(60, 60);
    wreg(4'hE, 8'h10);
    wait_int(60, 60);
    i_evts_src.set_pins(1'b0, 1'b0);
    new_live();
    @(posedge clk);
    sup_ev <= 1'b1;
    @(posedge clk);
    sup_ev <= 1'b0;
    i_evts_src.set_pins(1'b0, 1'b1);
    repeat (2) @(posedge clk);
    i_evts_src.set_pins(1'b1, 1'b1);
    wait_int(CAP - 6, CAP);
    stamps(1'b0, 1'b1, 1'b1);
    rreg(4'hF, 8'h48);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rreg(4'hF, 8'h30);
    rreg(4'hE, 8'h00);
    repeat (2) @(posedge clk);
    close_out();
  end
endmodule

bind evts_capture evts_chk i_evts_chk (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
  .rd(rd), .rdata(rdata), .adj_value(adj_value), .ctl1_value(ctl1_value), .bank_sel(bank_sel),
  .int_oe_n(int_oe_n));
`default_nettype wire
